// file: ista_checker.sv
// Purpose: Port-level protocol checks for the two-wire slave
// Assumes: Open-drain pins with pull-ups, zero-wait APB
// Notes: Bound to every slave instance below
`timescale 1ns/10ps
module ista_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe_n,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic sub_clk,
	input wire logic serial_irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Access phase and unmapped decode
	wire logic acc = psel && penable;
	wire logic unmap = (paddr[31:4] != 28'h0) || (paddr[1:0] != 2'h0);
	chk_zero_wait: assert property (acc |-> pready)
		else $error("pready low in access phase");
	chk_unmapped_err: assert property (acc && unmap |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	chk_mapped_ok: assert property (acc && !unmap |-> !pslverr && prdata[31:8] == 24'h0)
		else $error("mapped access answered wrongly");
	chk_irq_pulse: assert property (serial_irq |=> !serial_irq)
		else $error("interrupt longer than one cycle");
	chk_pins_low: assert property (scl_out == 1'b0 && sda_out == 1'b0)
		else $error("pin drives a high level");
	chk_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
		else $error("data line moved while clock high");
	chk_stretch_low: assert property ($changed(scl_oe_n) |-> !scl_in)
		else $error("clock hold changed while clock high");
	chk_ack_stands: assert property ($fell(sda_oe_n) && !scl_in |=> !sda_oe_n [*4])
		else $error("driven bit released too early");
	chk_start_quiet: assert property (scl_in && $fell(sda_in) |-> sda_oe_n)
		else $error("slave pulled data line with clock high");
	cover property (serial_irq);
	cover property ($fell(scl_oe_n));
	cover property (acc && pslverr);
endmodule : ista_checker

bind ista_slave ista_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
	.scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .sub_clk(sub_clk), .serial_irq(serial_irq));

// file: ista_i2c_master.sv
// Purpose: Behavioural two-wire bus master
// Assumes: Lines resolved outside with pull-ups
// Notes: Tasks are called by the bench
`timescale 1ns/10ps
module ista_i2c_master (
	input wire logic pclk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_oe_n,
	output logic sda_oe_n
);
	localparam int QTR = 8; // Quarter bit in pclk cycles
	int stall_fail = 0; // Stretch waits that ran out
	initial begin
		scl_oe_n = 1'b1;
		sda_oe_n = 1'b1;
	end
	// One bit: set data, release clock, wait out stretching, sample
	task automatic clk_bit(input logic b, output logic r);
		int n;
		sda_oe_n <= b;
		repeat (QTR) @(posedge pclk);
		scl_oe_n <= 1'b1;
		n = 0;
		do begin // Slave may hold clock low
			@(posedge pclk);
			n++;
		end while (scl !== 1'b1 && n < 4000);
		if (n >= 4000) stall_fail++;
		repeat (QTR) @(posedge pclk);
		r = sda;
		scl_oe_n <= 1'b0;
		repeat (QTR) @(posedge pclk);
	endtask : clk_bit
	// Byte MSB first, then ninth clock
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
		output logic ao);
		for (int i = 7; i >= 0; i--) clk_bit(d[i], q[i]);
		clk_bit(ai, ao);
	endtask : xfer
	// Data falls while clock high
	task automatic start_c();
		sda_oe_n <= 1'b1;
		scl_oe_n <= 1'b1;
		repeat (QTR) @(posedge pclk);
		sda_oe_n <= 1'b0;
		repeat (QTR) @(posedge pclk);
		scl_oe_n <= 1'b0;
		repeat (QTR) @(posedge pclk);
	endtask : start_c
	// Data rises while clock high
	task automatic stop_c();
		sda_oe_n <= 1'b0;
		repeat (QTR) @(posedge pclk);
		scl_oe_n <= 1'b1;
		repeat (QTR) @(posedge pclk);
		sda_oe_n <= 1'b1;
		repeat (QTR) @(posedge pclk);
	endtask : stop_c
endmodule : ista_i2c_master

// file: ista_pkg.sv
// Purpose: Shared constants for the two-wire slave with bus time-out
// Assumes: APB word registers, 8-bit data in the low bits
// Notes: Status bit positions apply to the control/status register
package ista_pkg;
	// Register byte offsets
	localparam logic [3:0] ISTA_OFF_DATA = 4'h0;
	localparam logic [3:0] ISTA_OFF_ADDR = 4'h4;
	localparam logic [3:0] ISTA_OFF_CTRL = 4'h8;
	localparam logic [3:0] ISTA_OFF_TOUT = 4'hC;
	// Control/status bit positions
	localparam int ISTA_B_ACK_RECEIVED_FLAG = 0;
	localparam int ISTA_B_SRW = 2;
	localparam int ISTA_B_ACK_TO_SEND = 3;
	localparam int ISTA_B_HTX = 4;
	localparam int ISTA_B_BUSY = 5;
	localparam int ISTA_B_ADDRESSED_AS_SLAVE_FLAG = 6;
	// Time-out register bit positions
	localparam int ISTA_B_TOEN = 7;
	localparam int ISTA_B_TOF = 6;
	localparam int ISTA_TOS_W = 6;
	// Power-on values
	localparam logic [7:0] ISTA_POR_DATA = 8'h00;
	localparam logic [6:0] ISTA_POR_ADDR = 7'h00;
	localparam logic [7:0] ISTA_POR_TOUT = 8'h00;
	localparam logic ISTA_POR_ACK_RECEIVED_FLAG = 1'b1;
	// Sub-clock divide and counter widths
	localparam int ISTA_SUB_DIV = 32;
	localparam int ISTA_DIV_W = 5;
	localparam logic [3:0] ISTA_BITS = 4'h8;
	localparam logic [3:0] ISTA_LAST = 4'h7;
	// Slave protocol states
	typedef enum logic [2:0] {
		ISTA_IDLE, ISTA_ADDR, ISTA_AACK, ISTA_RXD, ISTA_RACK, ISTA_TXD, ISTA_TACK, ISTA_IGN
	} ista_state_type;
endpackage : ista_pkg

// file: ista_slave.sv
// Purpose: Two-wire serial slave with address match, ack and bus time-out
// Assumes: APB slave, pins open drain, sub-clock arrives on a pin
// Notes: What this block does is summarised below
`timescale 1ns/10ps
module ista_slave
	import ista_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_n,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic sub_clk,
	output logic serial_irq
);
	logic [2:0] pins_s; // Synchronised sub_clk, sda, scl
	logic scl_s, sda_s, sub_s; // Synced clock, data and sub-clock lines
	logic scl_d, sda_d, sub_d; // Previous synced levels
	logic scl_rise, scl_fall, start_seen, stop_seen, sub_tick; // Pin events
	logic tout; // Time-out overflow pulse
	ista_state_type state; // Sequencer state
	logic [3:0] bit_cnt; // Bits in current byte
	logic [7:0] shift; // Serial shift register
	logic addr_match; // Seven address bits equal own address
	logic hold; // Clock stretch request
	logic sda_low; // Data line pulled low
	logic [7:0] serial_data_reg; // Data register
	logic [6:0] own_address_reg; // Own address register
	logic master_read_flag, addressed_as_slave_flag, bus_busy_flag; // Status flags
	logic slave_transmit_select, ack_to_send, ack_received_flag; // Control and ack bits
	logic timeout_enable, timeout_flag; // Time-out control bits
	logic [ISTA_TOS_W-1:0] timeout_period_select; // Time-out length field
	logic setup_ph, wr_acc, rd_acc; // APB setup, write taken, read taken
	logic mapped, data_wr, data_rd; // Decode and data register access
	logic [7:0] ctrl_rd; // Control/status read image
	logic [31:0] next_prdata; // Read data before the register
	logic match_ev, byte_ev; // Address matched, byte completed
	ista_sync #(
		.WIDTH(3)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({sub_clk, sda_in, scl_in}),
		.sync_out(pins_s)
	);
	assign scl_s = pins_s[0];
	assign sda_s = pins_s[1];
	assign sub_s = pins_s[2];
	// Edge history of the synchronised pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			sub_d <= 1'b1; // Same as synchroniser reset, no false tick
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			sub_d <= sub_s;
		end
	end
	assign scl_rise = scl_s && !scl_d;
	assign scl_fall = !scl_s && scl_d;
	assign start_seen = scl_s && scl_d && sda_d && !sda_s;
	assign stop_seen = scl_s && scl_d && !sda_d && sda_s;
	assign sub_tick = sub_s && !sub_d;
	assign addr_match = (shift[7:1] == own_address_reg); // Address above R/W bit
	ista_timeout #(
		.SEL_W(ISTA_TOS_W)
	) u_tout (
		.pclk(pclk),
		.presetn(presetn),
		.enable(timeout_enable),
		.period_sel(timeout_period_select),
		.sub_tick(sub_tick),
		.arm(match_ev),
		.scl_fall(scl_fall),
		.stop_seen(stop_seen),
		.overflow(tout)
	);
	// APB decode, zero wait states
	assign setup_ph = psel && !penable;
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign mapped = (paddr[31:4] == '0) && (paddr[1:0] == 2'b00);
	assign data_wr = wr_acc && mapped && pstrb[0] && (paddr[3:0] == ISTA_OFF_DATA);
	assign data_rd = rd_acc && mapped && (paddr[3:0] == ISTA_OFF_DATA);
	assign pready = penable;
	assign match_ev = (state == ISTA_ADDR) && scl_fall && (bit_cnt == ISTA_BITS) && addr_match;
	assign byte_ev = scl_fall && (((state == ISTA_RXD) && (bit_cnt == ISTA_BITS))
		|| ((state == ISTA_TACK) && !ack_received_flag));
	// Control/status read image
	always_comb begin
		ctrl_rd = 8'h00;
		ctrl_rd[ISTA_B_ACK_RECEIVED_FLAG] = ack_received_flag;
		ctrl_rd[ISTA_B_SRW] = master_read_flag;
		ctrl_rd[ISTA_B_ACK_TO_SEND] = ack_to_send;
		ctrl_rd[ISTA_B_HTX] = slave_transmit_select;
		ctrl_rd[ISTA_B_BUSY] = bus_busy_flag;
		ctrl_rd[ISTA_B_ADDRESSED_AS_SLAVE_FLAG] = addressed_as_slave_flag;
	end
	// Read data mux, sampled in the setup cycle
	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr[3:0])
			ISTA_OFF_DATA: next_prdata[7:0] = serial_data_reg;
			ISTA_OFF_ADDR: next_prdata[6:0] = own_address_reg;
			ISTA_OFF_CTRL: next_prdata[7:0] = ctrl_rd;
			ISTA_OFF_TOUT: next_prdata[7:0] = {timeout_enable, timeout_flag, timeout_period_select};
			default: next_prdata = 32'h0000_0000;
		endcase
	end
	// Registered read data and error answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_ph) begin
			prdata <= mapped ? next_prdata : 32'h0000_0000;
			pslverr <= !mapped;
		end
	end

	// Address register, untouched by time-out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			own_address_reg <= ISTA_POR_ADDR;
		end else if (wr_acc && mapped && pstrb[0] && (paddr[3:0] == ISTA_OFF_ADDR)) begin
			own_address_reg <= pwdata[6:0];
		end
	end

	// Data register: software writes, received bytes land here
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_data_reg <= ISTA_POR_DATA;
		end else if (data_wr) begin
			serial_data_reg <= pwdata[7:0];
		end else if (byte_ev && (state == ISTA_RXD)) begin
			serial_data_reg <= shift;
		end
	end

	// Software-steered control bits, back to POR on time-out
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slave_transmit_select <= 1'b0;
			ack_to_send <= 1'b0;
		end else if (tout) begin
			slave_transmit_select <= 1'b0;
			ack_to_send <= 1'b0;
		end else if (wr_acc && mapped && pstrb[0] && (paddr[3:0] == ISTA_OFF_CTRL)) begin
			slave_transmit_select <= pwdata[ISTA_B_HTX];
			ack_to_send <= pwdata[ISTA_B_ACK_TO_SEND];
		end
	end

	// Time-out control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timeout_enable <= ISTA_POR_TOUT[ISTA_B_TOEN];
			timeout_flag <= ISTA_POR_TOUT[ISTA_B_TOF];
			timeout_period_select <= ISTA_POR_TOUT[ISTA_TOS_W-1:0];
		end else begin
			if (wr_acc && mapped && pstrb[0] && (paddr[3:0] == ISTA_OFF_TOUT)) begin
				timeout_enable <= pwdata[ISTA_B_TOEN];
				timeout_period_select <= pwdata[ISTA_TOS_W-1:0];
				if (!pwdata[ISTA_B_TOF]) begin
					timeout_flag <= 1'b0;
				end
			end
			if (tout) begin
				timeout_enable <= 1'b0;
				timeout_flag <= 1'b1;
			end
		end
	end

	// Bus busy between START and STOP
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_busy_flag <= 1'b0;
		end else if (tout || stop_seen) begin
			bus_busy_flag <= 1'b0;
		end else if (start_seen) begin
			bus_busy_flag <= 1'b1;
		end
	end

	// Direction and addressed flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			master_read_flag <= 1'b0;
			addressed_as_slave_flag <= 1'b0;
		end else if (tout) begin
			master_read_flag <= 1'b0;
			addressed_as_slave_flag <= 1'b0;
		end else if (match_ev) begin
			master_read_flag <= shift[0];
			addressed_as_slave_flag <= 1'b1;
		end else if (start_seen || data_wr || data_rd) begin
			addressed_as_slave_flag <= 1'b0;
		end
	end

	// Acknowledge sampled from the master after a sent byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_received_flag <= ISTA_POR_ACK_RECEIVED_FLAG;
		end else if (tout) begin
			ack_received_flag <= ISTA_POR_ACK_RECEIVED_FLAG;
		end else if ((state == ISTA_TACK) && scl_rise) begin
			ack_received_flag <= sda_s;
		end
	end

	// One shared interrupt pulse for all three causes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_irq <= 1'b0;
		end else begin
			serial_irq <= match_ev || byte_ev || tout;
		end
	end

	// Protocol sequencer, shift register and pin drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ISTA_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			hold <= 1'b0;
			sda_low <= 1'b0;
		end else if (tout || stop_seen) begin
			state <= ISTA_IDLE;
			bit_cnt <= 4'h0;
			hold <= 1'b0;
			sda_low <= 1'b0;
		end else if (start_seen) begin
			state <= ISTA_ADDR;
			bit_cnt <= 4'h0;
			hold <= 1'b0;
			sda_low <= 1'b0;
		end else begin
			case (state)
				ISTA_ADDR: begin
					if (scl_rise && (bit_cnt != ISTA_BITS)) begin
						shift <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 1'b1;
					end else if (scl_fall && (bit_cnt == ISTA_BITS)) begin
						shift <= {1'b0, shift[7:1]}; // Align address to low bits
						if (addr_match) begin
							state <= ISTA_AACK;
							sda_low <= 1'b1;
						end else begin
							state <= ISTA_IGN;
						end
					end
				end
				ISTA_AACK: begin
					if (scl_fall) begin
						sda_low <= 1'b0;
						hold <= 1'b1;
						bit_cnt <= 4'h0;
						state <= master_read_flag ? ISTA_TXD : ISTA_RXD;
					end
				end
				ISTA_RXD: begin
					if (hold) begin
						if (data_rd) begin
							hold <= 1'b0;
						end
					end else if (scl_rise && (bit_cnt != ISTA_BITS)) begin
						shift <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 1'b1;
					end else if (scl_fall && (bit_cnt == ISTA_BITS)) begin
						state <= ISTA_RACK;
						sda_low <= !ack_to_send;
					end
				end
				ISTA_RACK: begin
					if (scl_fall) begin
						sda_low <= 1'b0;
						hold <= 1'b1;
						bit_cnt <= 4'h0;
						state <= ISTA_RXD;
					end
				end
				ISTA_TXD: begin
					if (hold) begin
						if (data_wr) begin
							shift <= {pwdata[6:0], 1'b0};
							sda_low <= !pwdata[7];
							hold <= 1'b0;
						end
					end else if (scl_fall) begin
						if (bit_cnt == ISTA_LAST) begin
							sda_low <= 1'b0;
							state <= ISTA_TACK;
						end else begin
							sda_low <= !shift[7];
							shift <= {shift[6:0], 1'b0};
						end
						bit_cnt <= bit_cnt + 1'b1;
					end
				end
				ISTA_TACK: begin
					if (scl_fall) begin
						bit_cnt <= 4'h0;
						if (ack_received_flag) begin
							state <= ISTA_IGN;
						end else begin
							hold <= 1'b1;
							state <= ISTA_TXD;
						end
					end
				end
				ISTA_IDLE, ISTA_IGN: begin
					sda_low <= 1'b0;
				end
				default: begin
					state <= ISTA_IDLE;
				end
			endcase
		end
	end
	// Open-drain pins: enable low while pulling low
	assign sda_out = 1'b0;
	assign scl_out = 1'b0;
	assign sda_oe_n = !sda_low;
	assign scl_oe_n = !hold;
endmodule : ista_slave

// file: ista_sync.sv
// Purpose: Two-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to pclk
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
module ista_sync #(
	parameter int WIDTH = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta; // First stage
	genvar i;
	// One synchroniser chain per bit, idle pins read high
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					meta[i] <= 1'b1;
					sync_out[i] <= 1'b1;
				end else begin
					meta[i] <= async_in[i];
					sync_out[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule : ista_sync

// file: ista_timeout.sv
// Purpose: Bus time-out counter clocked by sub-clock ticks divided by 32
// Assumes: sub_tick is a one-cycle pulse per sub-clock rising edge
// Notes: Overflow is a one-cycle pulse and halts the counter
`timescale 1ns/10ps
module ista_timeout
	import ista_pkg::*;
#(
	parameter int SEL_W = ISTA_TOS_W
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic [SEL_W-1:0] period_sel,
	input wire logic sub_tick,
	input wire logic arm,
	input wire logic scl_fall,
	input wire logic stop_seen,
	output logic overflow
);
	logic active; // Counting window open
	logic [ISTA_DIV_W-1:0] div_cnt; // Sub-clock prescale by 32
	logic [SEL_W-1:0] per_cnt; // Elapsed prescaled periods
	logic period_end; // Last prescaled tick of the selected length
	assign period_end = sub_tick && (&div_cnt) && (per_cnt == period_sel);
	// Window opens on match, closes on stop or overflow
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active <= 1'b0;
		end else if (arm) begin
			active <= 1'b1;
		end else if (stop_seen || (active && enable && period_end)) begin
			active <= 1'b0;
		end
	end
	// Counter restarts on arm and on every clock-line fall
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= '0;
			per_cnt <= '0;
		end else if (arm || scl_fall) begin
			div_cnt <= '0;
			per_cnt <= '0;
		end else if (active && enable && sub_tick) begin
			div_cnt <= div_cnt + 1'b1;
			if (&div_cnt) begin
				per_cnt <= per_cnt + 1'b1;
			end
		end
	end
	// Overflow after (sel+1) periods of sub-clock/32
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			overflow <= 1'b0;
		end else begin
			overflow <= active && enable && period_end && !arm && !scl_fall;
		end
	end
endmodule : ista_timeout

// file: tb_top.sv
// Purpose: Self-checking bench for the two-wire slave
// Assumes: Pins resolved here with pull-ups
// Notes: Fast sub-clock keeps time-outs short
`timescale 1ns/10ps
module tb_top
	import ista_pkg::*;
();
	typedef struct {
		logic [31:0] a;
		logic [7:0] wd;
		logic [31:0] rd;
		logic er;
	} ista_row_type; // Write, then read back
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata;
	logic [3:0] pstrb;
	logic scl_out, scl_oe_n, sda_out, sda_oe_n, sub_clk, serial_irq;
	logic m_scl_oe_n, m_sda_oe_n; // Master enables
	wire logic scl = (scl_oe_n | scl_out) & m_scl_oe_n; // Pulled up
	wire logic sda = (sda_oe_n | sda_out) & m_sda_oe_n;
	int failures = 0;
	int cmp_count = 0;
	int irq_cnt = 0;
	int n;
	logic [7:0] q;
	logic ak;
	ista_row_type rows [9];
	ista_slave i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
		.scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.sub_clk(sub_clk), .serial_irq(serial_irq));
	ista_i2c_master i_mst (.pclk(pclk), .scl(scl), .sda(sda), .scl_oe_n(m_scl_oe_n),
		.sda_oe_n(m_sda_oe_n));
	// Clocks: 5 ns bus clock, 20 ns sub-clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		sub_clk = 1'b0;
		forever #10 sub_clk = ~sub_clk;
	end
	// Count interrupt pulses
	always @(posedge pclk) begin
		if (serial_irq === 1'b1) irq_cnt <= irq_cnt + 1;
	end
	task automatic give_verdict();
		if (failures == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// One APB transfer, held until pready
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 50) begin
			failures++;
			give_verdict();
		end
	endtask : apb
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, {24'h0, d}, r, e);
	endtask : wr
	task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		check(r, exp);
	endtask : rdc
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'hF;
		rows = '{'{32'h4, 8'hDA, 32'h5A, 1'b0}, '{32'h8, 8'hFF, 32'h19, 1'b0},
			'{32'h8, 8'h00, 32'h01, 1'b0}, '{32'hC, 8'h3F, 32'h3F, 1'b0},
			'{32'hC, 8'h7F, 32'h3F, 1'b0}, '{32'hC, 8'h00, 32'h00, 1'b0},
			'{32'h0, 8'hA5, 32'hA5, 1'b0}, '{32'h10, 8'h55, 32'h0, 1'b1},
			'{32'h6, 8'h55, 32'h0, 1'b1}};
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// Power-on values
		rdc(32'h8, 32'h01);
		rdc(32'hC, 32'h00);
		// Register table rows
		foreach (rows[i]) begin
			logic [31:0] r;
			logic e;
			apb(1'b1, rows[i].a, {24'h0, rows[i].wd}, r, e);
			apb(1'b0, rows[i].a, 32'h0, r, e);
			check(r, rows[i].rd);
			check(e, rows[i].er);
		end
		// Master writes two bytes
		i_mst.start_c();
		i_mst.xfer({7'h5A, 1'b0}, 1'b1, q, ak);
		check(ak, 1'b0);
		check(scl_oe_n, 1'b0);
		check(irq_cnt, 1);
		rdc(32'h8, 32'h61);
		rdc(32'h0, 32'hA5);
		rdc(32'h8, 32'h21);
		i_mst.xfer(8'hC3, 1'b1, q, ak);
		check(ak, 1'b0);
		check(irq_cnt, 2);
		rdc(32'h0, 32'hC3);
		wr(32'h8, 8'h08);
		i_mst.xfer(8'h3C, 1'b1, q, ak);
		check(ak, 1'b1);
		rdc(32'h0, 32'h3C);
		i_mst.stop_c();
		rdc(32'h8, 32'h09);
		// Master reads, time-out armed but fed by clock falls
		wr(32'h8, 8'h00);
		wr(32'hC, 8'h80);
		i_mst.start_c();
		i_mst.xfer({7'h5A, 1'b1}, 1'b1, q, ak);
		check(ak, 1'b0);
		rdc(32'h8, 32'h65);
		wr(32'h0, 8'hA6);
		i_mst.xfer(8'hFF, 1'b0, q, ak);
		check(q, 8'hA6);
		check(irq_cnt, 5);
		rdc(32'h8, 32'h24);
		wr(32'h0, 8'h59);
		i_mst.xfer(8'hFF, 1'b1, q, ak);
		check(q, 8'h59);
		check(sda_oe_n, 1'b1);
		rdc(32'h8, 32'h25);
		i_mst.stop_c();
		repeat (300) @(posedge pclk);
		check(irq_cnt, 5);
		rdc(32'hC, 32'h80);
		// Foreign address is ignored
		i_mst.start_c();
		i_mst.xfer({7'h11, 1'b0}, 1'b1, q, ak);
		check(ak, 1'b1);
		i_mst.xfer(8'h00, 1'b1, q, ak);
		check(ak, 1'b1);
		check(irq_cnt, 5);
		i_mst.stop_c();
		// Time-out while clock is held, period field 1
		wr(32'hC, 8'h81);
		i_mst.start_c();
		i_mst.xfer({7'h5A, 1'b0}, 1'b1, q, ak);
		n = 0;
		while (irq_cnt < 7 && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		check(n >= 240 && n <= 280, 1'b1);
		rdc(32'hC, 32'h41);
		rdc(32'h8, 32'h01);
		rdc(32'h4, 32'h5A);
		rdc(32'h0, 32'h59);
		check({scl_oe_n, sda_oe_n}, 2'h3);
		wr(32'hC, 8'h01);
		rdc(32'hC, 32'h01);
		i_mst.stop_c();
		// Second reset in mid-run
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rdc(32'h4, 32'h00);
		check(i_mst.stall_fail, 0);
		give_verdict();
	end
endmodule : tb_top
